// ---- src/pll_channel_program_sequencer.v ----
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`include "pll_channel_program_sequencer_defines.vh"

module pll_channel_program_sequencer #(
	parameter [16:0] MS_CYCLES = `MS_CYCLES
) (
	input wire mclk,
	input wire sys_rst,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg synthClk,
	output reg synthData,
	output reg loadStrobe,
	output reg supplyEnable,
	output reg transmitSelectN,
	output reg receiveSelectN,
	output reg txDataIn,
	input wire lockIndicator,
	input wire userTxBit,
	output reg dataReady
);

// ----------------------------------------
// states, one-hot
// ----------------------------------------
localparam [4:0] S_OFF = 5'h01;
localparam [4:0] S_IDLE = 5'h02;
localparam [4:0] S_SHIFT = 5'h04;
localparam [4:0] S_STROBE = 5'h08;
localparam [4:0] S_SETTLE = 5'h10;
localparam [7:0] SCLK_HALF = `SCLK_HALF_CYCLES;

// ----------------------------------------
// functions
// ----------------------------------------
// byte-lane merge of a register write
function [31:0] merge;
	input [31:0] old;
	input [31:0] din;
	input [3:0] strb;
	integer i;
	begin
		merge = old;
		for (i = 0; i < 4; i = i + 1) begin
			if (strb[i]) begin
				merge[i*8 +: 8] = din[i*8 +: 8];
			end
		end
	end
endfunction

// setting word for one latch; latch bit is the lsb, so shifted last
function [18:0] build_word;
	input toRef;
	input [6:0] ch;
	reg [14:0] total;
	begin
		total = `DIV_BASE + {8'h00, ch}; // RL17
		if (toRef) begin
			// options lead the reference count
			build_word = {`CP_CURRENT, `LOCK_OUT_SEL, `PHASE_POL, `REF_COUNT, // RL1 RL2 RL18 RL21
				`PRESCALER_SEL, `LATCH_REF}; // RL22
		end else begin
			// counter = total / 64, swallow = total mod 64
			build_word = {2'b00, total[14:6], 1'b0, total[5:0], `LATCH_CNT}; // RL19 RL20
		end
	end
endfunction

// ----------------------------------------
// software-visible registers
// ----------------------------------------
reg powerReq; // software asks for module power
reg modeReq; // 0 receive, 1 transmit
reg pairsMode; // paired preamble bits for 9600 bps
reg preEnable; // preamble on transmit entry
reg [6:0] channel; // requested channel index
reg [15:0] preDiv; // preamble bit period in mclk cycles
reg chanReq; // one-cycle change request
reg refused; // sticky: change request refused
reg lockOk; // lock confirmed at last check
reg lockChecked; // a lock check has been made

// ----------------------------------------
// sequencer state
// ----------------------------------------
reg [4:0] state;
reg appliedMode; // mode currently on the select pins
reg firstDone; // a channel has been set since power-up
reg [6:0] chanLatched; // channel being programmed
reg wordSel; // 0 reference word, 1 counter word
reg [4:0] bitIdx; // bit being presented
reg [7:0] halfDiv; // serial clock half-period divider
reg [16:0] msDiv; // millisecond divider
reg [5:0] msCount; // elapsed milliseconds in settle
reg [5:0] settleTarget; // settle length in ms
reg lockPending; // lock to be checked in this settle
reg preambleOn;
reg [15:0] preCnt;
reg [1:0] prePhase;
reg lockMeta;
reg lockSync;
reg [7:0] lockRun; // cycles the lock indicator has stayed high

wire halfTick = (halfDiv == SCLK_HALF - 8'h01);
wire msTick = (msDiv == MS_CYCLES - 17'h00001);
wire [18:0] curWord = build_word(~wordSel, chanLatched);
wire [18:0] refSetting = build_word(1'b1, chanLatched); // same for every channel
wire [18:0] cntSetting = build_word(1'b0, chanLatched); // second word of a change
wire [31:0] preMerged = merge({16'h0, preDiv}, s_axi_wdata, s_axi_wstrb); // lanes 0 and 1 kept
wire lockStable = &lockRun;
wire wrFire = s_axi_awready & s_axi_wready;
wire rdFire = s_axi_arready;
wire busy = ~state[1] & ~state[0];
wire [31:0] ctrlValue = {27'h0, preEnable, 1'b0, pairsMode, modeReq, powerReq};
wire [31:0] statValue = {19'h0, state, 2'b00, refused, lockOk, lockChecked,
	dataReady, appliedMode, busy};

// ----------------------------------------
// axi4-lite write channel
// ----------------------------------------
// address and data taken together; one write outstanding
always @(posedge mclk) begin
	if (sys_rst) begin
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'b00;
		powerReq <= 1'b0;
		modeReq <= 1'b0;
		pairsMode <= 1'b0;
		preEnable <= 1'b1;
		channel <= 7'h00;
		preDiv <= `PRE_DIV_RESET;
		chanReq <= 1'b0;
	end else begin
		chanReq <= 1'b0;
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		if (s_axi_bvalid & s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
		if (s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~wrFire) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
		if (wrFire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= 2'b00;
			case (s_axi_awaddr)
				`ADDR_CTRL: begin
					if (s_axi_wstrb[0]) begin
						powerReq <= s_axi_wdata[`CTRL_POWER];
						modeReq <= s_axi_wdata[`CTRL_MODE];
						pairsMode <= s_axi_wdata[`CTRL_PAIRS];
						preEnable <= s_axi_wdata[`CTRL_PRE_EN];
						chanReq <= s_axi_wdata[`CTRL_CHANGE];
					end
				end
				`ADDR_CHAN: begin
					if (s_axi_wstrb[0]) begin
						channel <= s_axi_wdata[6:0];
					end
				end
				`ADDR_STAT: begin
					// write-one-to-clear handled in the sequencer
				end
				`ADDR_PRE: begin
					preDiv <= preMerged[15:0];
				end
				default: begin
					s_axi_bresp <= 2'b10; // unmapped: slave error
				end
			endcase
		end
	end
end

// ----------------------------------------
// axi4-lite read channel
// ----------------------------------------
// data registered one cycle after the address is taken
always @(posedge mclk) begin
	if (sys_rst) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0;
		s_axi_rresp <= 2'b00;
	end else begin
		s_axi_arready <= s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
		if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
		if (rdFire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			case (s_axi_araddr)
				`ADDR_CTRL: s_axi_rdata <= ctrlValue;
				`ADDR_CHAN: s_axi_rdata <= {25'h0, channel};
				`ADDR_STAT: s_axi_rdata <= statValue;
				`ADDR_PRE: s_axi_rdata <= {16'h0, preDiv};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end
	end
end

// ----------------------------------------
// lock indicator synchroniser and filter
// ----------------------------------------
// the indicator may chatter before true lock, so a run of highs is needed
always @(posedge mclk) begin
	if (sys_rst) begin
		lockMeta <= 1'b0;
		lockSync <= 1'b0;
		lockRun <= 8'h00;
	end else begin
		lockMeta <= lockIndicator;
		lockSync <= lockMeta;
		if (!lockSync) begin
			lockRun <= 8'h00; // RL14
		end else if (!lockStable) begin
			lockRun <= lockRun + 8'h01;
		end
	end
end

// ----------------------------------------
// dividers
// ----------------------------------------
// both restart on entry so each interval is whole
always @(posedge mclk) begin
	if (sys_rst) begin
		halfDiv <= 8'h00;
		msDiv <= 17'h00000;
	end else begin
		if (!(state[2] | state[3]) | halfTick) begin
			halfDiv <= 8'h00;
		end else begin
			halfDiv <= halfDiv + 8'h01;
		end
		if (!state[4] | msTick) begin
			msDiv <= 17'h00000; // RL26
		end else begin
			msDiv <= msDiv + 17'h00001;
		end
	end
end

// ----------------------------------------
// preamble and data pin
// ----------------------------------------
always @(posedge mclk) begin
	if (sys_rst) begin
		preCnt <= 16'h0000;
		prePhase <= 2'b00;
		txDataIn <= 1'b0;
	end else if (preambleOn) begin
		if (preCnt >= preDiv - 16'h0001) begin
			preCnt <= 16'h0000;
			prePhase <= prePhase + 2'b01;
		end else begin
			preCnt <= preCnt + 16'h0001;
		end
		if (pairsMode) begin
			txDataIn <= ~prePhase[1]; // RL16
		end else begin
			txDataIn <= ~prePhase[0]; // RL15
		end
	end else begin
		preCnt <= 16'h0000;
		prePhase <= 2'b00;
		// user data only once settled in transmit
		txDataIn <= dataReady & appliedMode & userTxBit; // RL26
	end
end

// ----------------------------------------
// power, channel and mode sequencer
// ----------------------------------------
always @(posedge mclk) begin
	if (sys_rst) begin
		state <= S_OFF;
		supplyEnable <= 1'b0; // RL7
		transmitSelectN <= 1'b1; // RL7
		receiveSelectN <= 1'b1; // RL7
		synthClk <= 1'b0;
		synthData <= 1'b0;
		loadStrobe <= 1'b0;
		dataReady <= 1'b0;
		appliedMode <= 1'b0;
		firstDone <= 1'b0;
		chanLatched <= 7'h00;
		wordSel <= 1'b0;
		bitIdx <= 5'h00;
		msCount <= 6'h00;
		settleTarget <= 6'h00;
		lockPending <= 1'b0;
		preambleOn <= 1'b0;
		refused <= 1'b0;
		lockOk <= 1'b0;
		lockChecked <= 1'b0;
	end else begin
		// clear first, so a refusal in the same cycle still sets
		if (wrFire && s_axi_awaddr == `ADDR_STAT && s_axi_wstrb[0]
			&& s_axi_wdata[`STAT_REFUSED]) begin
			refused <= 1'b0;
		end
		if (chanReq && !(state[1] && powerReq && !appliedMode && !modeReq
			&& channel < `NUM_CHANNELS)) begin
			refused <= 1'b1; // RL10
		end
		case (state)
			S_OFF: begin
				// selects stay inactive until the supply is up
				if (powerReq) begin
					supplyEnable <= 1'b1;
					state <= S_IDLE;
				end
			end
			S_IDLE: begin
				if (!powerReq) begin
					supplyEnable <= 1'b0;
					transmitSelectN <= 1'b1;
					receiveSelectN <= 1'b1;
					dataReady <= 1'b0;
					appliedMode <= 1'b0;
					firstDone <= 1'b0;
					state <= S_OFF;
				end else if (chanReq && !appliedMode && !modeReq
					&& channel < `NUM_CHANNELS) begin
					// retune only while receiving
					receiveSelectN <= 1'b0; // RL10
					transmitSelectN <= 1'b1; // RL24
					chanLatched <= channel;
					dataReady <= 1'b0;
					wordSel <= 1'b0; // RL6
					bitIdx <= 5'h12;
					synthData <= refSetting[18]; // RL25
					synthClk <= 1'b0;
					state <= S_SHIFT;
				end else if (firstDone && modeReq != appliedMode) begin
					appliedMode <= modeReq;
					transmitSelectN <= ~modeReq; // RL24
					receiveSelectN <= modeReq; // RL24
					dataReady <= 1'b0;
					msCount <= 6'h00;
					lockPending <= 1'b0;
					preambleOn <= modeReq & preEnable; // RL15
					if (modeReq && preEnable) begin
						settleTarget <= `PREAMBLE_MS; // RL15
					end else begin
						settleTarget <= `MODE_SETTLE_MS; // RL11 RL12
					end
					state <= S_SETTLE;
				end
			end
			S_SHIFT: begin
				if (halfTick) begin
					if (!synthClk) begin
						synthClk <= 1'b1; // RL3
					end else begin
						synthClk <= 1'b0;
						if (bitIdx == 5'h00) begin
							state <= S_STROBE; // RL4
						end else begin
							bitIdx <= bitIdx - 5'h01;
							synthData <= curWord[bitIdx - 5'h01]; // RL25
						end
					end
				end
			end
			S_STROBE: begin
				if (halfTick) begin
					if (!loadStrobe) begin
						loadStrobe <= 1'b1; // RL5
					end else begin
						loadStrobe <= 1'b0; // RL25
						if (!wordSel) begin
							wordSel <= 1'b1;
							bitIdx <= 5'h12;
							synthData <= cntSetting[18];
							state <= S_SHIFT;
						end else begin
							msCount <= 6'h00;
							lockPending <= 1'b1;
							if (firstDone) begin
								settleTarget <= `LATER_SETTLE_MS; // RL9
							end else begin
								settleTarget <= `FIRST_SETTLE_MS; // RL8
							end
							firstDone <= 1'b1;
							state <= S_SETTLE;
						end
					end
				end
			end
			S_SETTLE: begin
				if (msTick) begin
					msCount <= msCount + 6'h01;
					if (lockPending && msCount + 6'h01 == `LOCK_CHECK_MS) begin
						lockOk <= lockSync & lockStable; // RL13 RL23
						lockChecked <= 1'b1;
						lockPending <= 1'b0;
					end
					if (msCount + 6'h01 == settleTarget) begin
						dataReady <= 1'b1; // RL26
						preambleOn <= 1'b0;
						state <= S_IDLE;
					end
				end
			end
			default: begin
				state <= S_OFF;
			end
		endcase
	end
end

endmodule

// ---- src/pll_channel_program_sequencer_defines.vh ----
// Summary of operation
// [RL1] send lock output select as zero
// [RL2] send phase polarity bit as one
// [RL3] synthesizer shifts data on serial clock rise
// [RL4] latch target bit goes last, picks latch
// [RL5] load strobe copies word into chosen latch
// [RL6] reference and counter words in any order
// [RL7] supply and selects inactive before power on
// [RL8] wait 40 ms after first channel set
// [RL9] wait 20 ms after later channel changes
// [RL10] reprogram channel only in receive mode
// [RL11] receive on same channel after 5 ms
// [RL12] transmit data 5 ms after switching over; with preEnable set, the preamble starts at once and user data follows at 15 ms
// [RL13] check lock indicator high at 20 ms
// [RL14] ignore early unstable lock indicator transitions
// [RL15] send alternating preamble 15 ms on transmit
// [RL16] at 9600 bps use paired preamble bits
// [RL17] 69 channels, 25 kHz steps from base
// [RL18] reference count 850, prescaler 64
// [RL19] counter value is total division over 64
// [RL20] swallow value is total division modulo 64
// [RL21] send charge pump current bit as zero
// [RL22] option bits lead the reference word
// [RL23] lock indicator high while locked
// [RL24] selects active low, one path at once
// [RL25] msb first, strobe pulse after last bit
// [RL26] millisecond timer blocks traffic until settled
`ifndef PLL_CHANNEL_PROGRAM_SEQUENCER_DEFINES_VH
`define PLL_CHANNEL_PROGRAM_SEQUENCER_DEFINES_VH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_CHAN 8'h04
`define ADDR_STAT 8'h08
`define ADDR_PRE 8'h0c

// ctrl field positions
`define CTRL_POWER 0
`define CTRL_MODE 1
`define CTRL_PAIRS 2
`define CTRL_CHANGE 3
`define CTRL_PRE_EN 4
// status field positions
`define STAT_REFUSED 5
// reset values
`define PRE_DIV_RESET 16'h3415

// ----------------------------------------
// synthesizer word contents
// ----------------------------------------
`define WORD_BITS 19
`define CP_CURRENT 1'b0
`define LOCK_OUT_SEL 1'b0
`define PHASE_POL 1'b1
`define PRESCALER_SEL 1'b1
`define REF_COUNT 14'h352
`define LATCH_REF 1'b1
`define LATCH_CNT 1'b0
`define DIV_BASE 15'h4047
`define NUM_CHANNELS 7'h45

// ----------------------------------------
// timing
// ----------------------------------------
`define MCLK_PERIOD_NS 8
`define MS_NS 1000000
`define MS_CYCLES 17'h1e848
`define SCLK_HALF_NS 1000
`define SCLK_HALF_CYCLES 8'h7d
`define FIRST_SETTLE_MS 6'h28
`define LATER_SETTLE_MS 6'h14
`define MODE_SETTLE_MS 6'h05
`define PREAMBLE_MS 6'h0f
`define LOCK_CHECK_MS 6'h14

`endif

// ---- verif/pll_seq_checker.sv ----
`timescale 1ns/1ns
module pll_seq_checker (
	input wire mclk,
	input wire sys_rst,
	input wire s_axi_awready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire synthClk,
	input wire synthData,
	input wire loadStrobe,
	input wire supplyEnable,
	input wire transmitSelectN,
	input wire receiveSelectN,
	input wire txDataIn,
	input wire dataReady
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// ------
	// pin rules
	// ------
	one_path_a: assert property (transmitSelectN || receiveSelectN)
		else $error("both selects low");
	quiet_power_a: assert property ($rose(supplyEnable) |-> transmitSelectN && receiveSelectN)
		else $error("select active at power on");
	shift_in_rx_a: assert property ($rose(synthClk) |-> transmitSelectN && !receiveSelectN)
		else $error("shift outside receive");
	strobe_clk_low_a: assert property (loadStrobe |-> !synthClk)
		else $error("clock high during strobe");
	strobe_width_a: assert property ($rose(loadStrobe) |-> ##124 loadStrobe ##1 !loadStrobe)
		else $error("strobe width wrong");
	clk_high_width_a: assert property ($rose(synthClk) |-> ##124 synthClk ##1 !synthClk)
		else $error("serial clock high time wrong");
	data_hold_a: assert property (synthClk && $past(synthClk) |-> $stable(synthData))
		else $error("data moved while clock high");
	no_ready_shift_a: assert property (synthClk |-> !dataReady)
		else $error("ready during shifting");
	tx_quiet_a: assert property (transmitSelectN && $past(transmitSelectN, 2) |-> !txDataIn)
		else $error("data driven outside transmit");
	// bus answers follow their handshake; the write response also holds
	wr_answer_a: assert property (s_axi_awready |=> s_axi_bvalid)
		else $error("no write response");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rd_answer_a: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("no read data");
endmodule
bind pll_channel_program_sequencer pll_seq_checker u_chk (.mclk(mclk), .sys_rst(sys_rst),
	.s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.synthClk(synthClk), .synthData(synthData), .loadStrobe(loadStrobe),
	.supplyEnable(supplyEnable), .transmitSelectN(transmitSelectN),
	.receiveSelectN(receiveSelectN), .txDataIn(txDataIn), .dataReady(dataReady));

// ---- verif/synth_model.sv ----
`timescale 1ns/1ns
module synth_model (
	input wire synthClk,
	input wire synthData,
	input wire loadStrobe,
	input wire supplyEnable,
	input wire locked,
	output reg [18:0] refWord,
	output reg [18:0] cntWord,
	output wire lockIndicator
);
	// ------
	// serial input and latches
	// ------
	reg [18:0] shiftReg = 19'h0; // shifted bits, newest at bit 0
	// shift on serial clock rise
	always @(posedge synthClk) shiftReg <= {shiftReg[17:0], synthData};
	// last bit picks the latch, whole word copied
	always @(posedge loadStrobe) begin
		if (shiftReg[0]) begin
			refWord <= shiftReg;
		end else begin
			cntWord <= shiftReg;
		end
	end
	// lock shown only while powered; bench picks lock state
	assign lockIndicator = supplyEnable & locked;
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ns
module tb;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_t;
	localparam int MS = 50; // short millisecond for simulation
	reg mclk = 0;
	reg sysRst = 1;
	reg [7:0] awaddr = 0;
	reg [7:0] araddr = 0;
	reg [31:0] wdata = 0;
	reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	reg userTxBit = 0, lockOn = 1;
	wire awready, wready, bvalid, arready, rvalid, synthClk, synthData, loadStrobe;
	wire supplyEnable, transmitSelectN, receiveSelectN, txDataIn, lockIndicator, dataReady;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [18:0] refWord, cntWord;
	int errors = 0, tests_run = 0, cyc = 0, strobeCyc = 0, t0 = 0, k;
	note_t notes[$]; // expected bus answers, oldest first
	note_t n;
	pll_channel_program_sequencer #(.MS_CYCLES(17'h00032)) u_dut (.mclk(mclk), .sys_rst(sysRst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.synthClk(synthClk), .synthData(synthData), .loadStrobe(loadStrobe),
		.supplyEnable(supplyEnable), .transmitSelectN(transmitSelectN),
		.receiveSelectN(receiveSelectN), .txDataIn(txDataIn), .lockIndicator(lockIndicator),
		.userTxBit(userTxBit), .dataReady(dataReady));
	synth_model u_synth (.synthClk(synthClk), .synthData(synthData), .loadStrobe(loadStrobe),
		.supplyEnable(supplyEnable), .locked(lockOn), .refWord(refWord), .cntWord(cntWord),
		.lockIndicator(lockIndicator));
	initial forever #4 mclk = ~mclk;
	// ------
	// shared tasks
	// ------
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// write: address and data offered together, held until taken
	task wr(input [7:0] a, input [31:0] d, input [1:0] r);
		notes.push_back({32'h0, 32'h0, r});
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'b111;
		@(posedge mclk);
		while (!awready) @(posedge mclk);
		{awvalid, wvalid} <= 2'b00;
		while (!bvalid) @(posedge mclk);
		bready <= 0;
		@(posedge mclk);
	endtask
	// read: m masks the bits compared
	task rd(input [7:0] a, input [31:0] m, input [31:0] e, input [1:0] r);
		notes.push_back({e, m, r});
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		@(posedge mclk);
		while (!arready) @(posedge mclk);
		arvalid <= 0;
		while (!rvalid) @(posedge mclk);
		rready <= 0;
		@(posedge mclk);
	endtask
	// wait for a fresh ready; small slack for pipeline stages
	task settle(input int lo, input bit fromStrobe);
		while (dataReady !== 1'b0) @(posedge mclk);
		while (dataReady !== 1'b1) @(posedge mclk);
		if (fromStrobe) t0 = strobeCyc;
		check("settle", (cyc - t0 >= lo) && (cyc - t0 <= lo + 8), 1);
	endtask
	task chan(input [6:0] c, input int ms);
		wr(8'h04, {25'h0, c}, 2'b00);
		wr(8'h00, 32'h19, 2'b00);
		settle(ms * MS, 1);
		check("refWord", refWord, {3'b001, 14'd850, 2'b11});
		check("cntWord", cntWord, {11'((16455 + c) >> 6), 7'((16455 + c) & 63), 1'b0});
	endtask
	// tx entry: preamble starts high, then low once gap more cycles have passed
	task tx_pre(input [31:0] ctl, input int gap);
		t0 = cyc;
		wr(8'h00, ctl, 2'b00);
		repeat (5) @(posedge mclk);
		check("preamble high", txDataIn, 1);
		repeat (gap) @(posedge mclk);
		check("preamble low", txDataIn, 0);
		settle(15 * MS, 0);
	endtask
	// ------
	// results, cycle count, random traffic bit, timeout
	// ------
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		userTxBit <= 1'($urandom);
		if (loadStrobe) strobeCyc <= cyc;
		if ((bvalid && bready) || (rvalid && rready)) begin
			n = notes.pop_front();
			if (rvalid && rready) check("rdata", rdata & n.m, n.d);
			check("resp", (rvalid && rready) ? rresp : bresp, n.r);
		end
		if (cyc == 40000) begin
			errors++;
			end_of_test;
		end
	end
	initial begin
		k = $urandom(32'h8715);
		repeat (3) @(posedge mclk);
		sysRst <= 0;
		@(posedge mclk);
		check("idle pins", {supplyEnable, transmitSelectN, receiveSelectN}, 3'b011);
		rd(8'h0c, 32'hffff, 32'h3415, 2'b00);
		rd(8'h00, 32'h1f, 32'h10, 2'b00);
		rd(8'h10, 32'hffffffff, 32'h0, 2'b10);
		wr(8'h10, 32'h1, 2'b10);
		$display("registers test done");
		wr(8'h00, 32'h11, 2'b00);
		k = $urandom % 69;
		chan(7'(k), 40);
		rd(8'h08, 32'h18, 32'h18, 2'b00);
		lockOn <= 0;
		chan(7'd68, 20);
		rd(8'h08, 32'h18, 32'h08, 2'b00);
		wr(8'h04, 32'h45, 2'b00);
		wr(8'h00, 32'h19, 2'b00);
		rd(8'h08, 32'h20, 32'h20, 2'b00);
		wr(8'h08, 32'h20, 2'b00);
		rd(8'h08, 32'h20, 32'h0, 2'b00);
		$display("channel test done");
		wr(8'h0c, 32'ha, 2'b00);
		rd(8'h0c, 32'hffff, 32'ha, 2'b00);
		tx_pre(32'h17, 20);
		rd(8'h08, 32'h06, 32'h06, 2'b00);
		check("tx pins", {transmitSelectN, receiveSelectN}, 2'b01);
		wr(8'h00, 32'h1b, 2'b00);
		rd(8'h08, 32'h20, 32'h20, 2'b00);
		t0 = cyc;
		wr(8'h00, 32'h11, 2'b00);
		settle(5 * MS, 0);
		check("rx pins", {transmitSelectN, receiveSelectN}, 2'b10);
		tx_pre(32'h13, 10);
		repeat (4) begin
			@(posedge mclk);
			k = userTxBit;
			@(posedge mclk);
			check("tx data", txDataIn, k);
		end
		$display("mode test done");
		end_of_test;
	end
endmodule
